// ---- hw/hub_identity_defines.vh ----
// Constants for the hub identity and configuration register bank.
// Assumes an SMBus slave engine that presents decoded byte transfers.
`ifndef HUB_IDENTITY_DEFINES_VH
`define HUB_IDENTITY_DEFINES_VH

// Register offsets
`define OFS_STATUS_COMMAND   8'h00
`define OFS_VENDOR_ID_LOW    8'h01
`define OFS_VENDOR_ID_HIGH   8'h02
`define OFS_PRODUCT_ID_LOW   8'h03
`define OFS_PRODUCT_ID_HIGH  8'h04
`define OFS_DEVICE_ID_LOW    8'h05
`define OFS_DEVICE_ID_HIGH   8'h06
`define OFS_HUB_CONFIG_FIRST 8'h07
`define OFS_HUB_CONFIG_SECOND 8'h08
`define OFS_PROTECT_LAST     8'h10

// Reset value of every register
`define REG_RESET_VALUE      8'h00

// First configuration byte fields
`define CFG1_POWER_SOURCE    7
`define CFG1_LED_SUPPORT     6
`define CFG1_FULL_SPEED_ONLY 5
`define CFG1_PER_PORT_TT     4
`define CFG1_EOP_SUPPRESS    3
`define CFG1_OC_MODE_HI      2
`define CFG1_OC_MODE_LO      1
`define CFG1_PORT_POWER      0

// Second configuration byte fields
`define HUB_CONFIG_SECOND_DYNAMIC_POWER   7
`define HUB_CONFIG_SECOND_RESERVED_BIT    6
`define HUB_CONFIG_SECOND_KEPT_MASK       8'hBF

// Status/command lock flag position
`define STCD_LOCK_BIT        1

// Bank storage depth
`define BANK_DEPTH           8

`endif

// ---- hw/hub_byte_store.v ----
// Small byte store for the identity and configuration bytes.
// Assumes one clock; read data come out of a register one cycle later.
`timescale 1ns/100ps

module hub_byte_store #(
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire          i_clk,      // Core clock
    input  wire          i_reset,    // Synchronous reset, clears all
    input  wire          i_we,       // Write strobe
    input  wire [AW-1:0] i_waddr,    // Write index
    input  wire [7:0]    i_wdata,    // Write byte
    input  wire [AW-1:0] i_raddr,    // Read index
    output reg  [7:0]    o_rdata     // Registered read byte
);

    reg [7:0] mem [0:DEPTH-1];
    integer   k;

    // Storage; reset clears every byte so defaults are known
    always @(posedge i_clk) begin
        if (i_reset) begin
            for (k = 0; k < DEPTH; k = k + 1) begin
                mem[k] <= 8'h00;
            end
            o_rdata <= 8'h00;
        end else begin
            if (i_we) begin
                mem[i_waddr] <= i_wdata;
            end
            o_rdata <= mem[i_raddr];
        end
    end

endmodule

// ---- hw/hub_identity_config_registers.v ----
// Identity and first two configuration bytes of a three-port hub.
// Assumes an SMBus slave engine on the same clock that decodes the
// protocol and presents each Write Byte / Read Byte as a one-cycle strobe.
`timescale 1ns/100ps
`include "hub_identity_defines.vh"

module hub_identity_config_registers (
    input  wire       i_clk,              // 125 MHz core clock
    input  wire       i_reset,            // Sync reset from pin, high
    input  wire       i_write_byte,       // Valid Write Byte strobe
    input  wire       i_read_byte,        // Valid Read Byte strobe
    input  wire       i_other_protocol,   // Any other protocol seen
    input  wire [7:0] i_command,          // Register offset of transfer
    input  wire [7:0] i_wdata,            // Byte to write
    input  wire       i_lock_set,         // Lock flag being set by host
    input  wire       i_local_power_sense_pin, // Local power present
    output reg  [7:0] o_rdata,            // Read byte
    output reg        o_rvalid,           // Read byte valid pulse
    output reg        o_write_refused,    // Write refused pulse
    output reg        o_config_lock_flag, // Lock flag state
    output reg  [7:0] o_vendor_code_low_byte,   // Vendor code low
    output reg  [7:0] o_vendor_code_high_byte,  // Vendor code high
    output reg  [7:0] o_product_code_low_byte,  // Product code low
    output reg  [7:0] o_product_code_high_byte, // Product code high
    output reg  [7:0] o_release_code_low_byte,  // Release code low
    output reg  [7:0] o_release_code_high_byte, // Release code high
    output reg        o_self_powered,     // Effective self power
    output reg        o_led_indicator_support,   // LED support
    output reg        o_full_speed_only,  // High speed removed
    output reg        o_per_port_translator_enable, // Multi translator
    output reg        o_frame_end_packet_suppress,  // EOF1 EOP off
    output reg  [1:0] o_overcurrent_sense_mode,     // Sense mode
    output reg        o_overcurrent_sense_off,      // Sensing disabled
    output reg        o_port_power_switch_mode,     // Per-port power
    output reg        o_dynamic_power_enable        // Auto switching
);

    // Offset to storage index; offsets 01h-08h map to 0-7
    function [2:0] slot;
        input [7:0] ofs;
        begin
            slot = ofs[2:0] - 3'h1;
        end
    endfunction

    // True for an offset held by this bank
    function in_bank;
        input [7:0] ofs;
        begin
            in_bank = (ofs >= `OFS_VENDOR_ID_LOW) &&
                      (ofs <= `OFS_HUB_CONFIG_SECOND);
        end
    endfunction

    // Sense pin passes two flops before use
    reg       sense_meta;
    reg       sense_sync;

    // Shadow copies of configuration bytes drive the decoded outputs
    reg [7:0] cfg_first;
    reg [7:0] cfg_second;

    reg       rd_pending;
    reg       rd_in_bank;
    reg       lock;
    reg       do_write;
    reg [7:0] kept_data;
    wire [7:0] store_rdata;

    // A write counts only on a Write Byte to a bank offset (01h-08h)
    // while unlocked; other protocols never reach the store
    always @* begin
        do_write  = i_write_byte && !i_other_protocol
                    && in_bank(i_command) && !lock;
        kept_data = i_wdata;
        if (i_command == `OFS_HUB_CONFIG_SECOND) begin
            kept_data = i_wdata & `HUB_CONFIG_SECOND_KEPT_MASK;
        end
    end

    hub_byte_store #(
        .DEPTH (`BANK_DEPTH),
        .AW    (3)
    ) u_store (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_we    (do_write),
        .i_waddr (slot(i_command)),
        .i_wdata (kept_data),
        .i_raddr (slot(i_command)),
        .o_rdata (store_rdata)
    );

    // Sense pin synchroniser
    always @(posedge i_clk) begin
        if (i_reset) begin
            sense_meta <= 1'b0;
            sense_sync <= 1'b0;
        end else begin
            sense_meta <= i_local_power_sense_pin;
            sense_sync <= sense_meta;
        end
    end

    // Lock flag; only the pin reset clears it, set is sticky
    always @(posedge i_clk) begin
        if (i_reset) begin
            lock <= 1'b0;
        end else if (i_lock_set && !i_other_protocol) begin
            lock <= 1'b1;
        end
    end

    // Identity bytes and configuration shadows follow accepted writes
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_vendor_code_low_byte   <= `REG_RESET_VALUE;
            o_vendor_code_high_byte  <= `REG_RESET_VALUE;
            o_product_code_low_byte  <= `REG_RESET_VALUE;
            o_product_code_high_byte <= `REG_RESET_VALUE;
            o_release_code_low_byte  <= `REG_RESET_VALUE;
            o_release_code_high_byte <= `REG_RESET_VALUE;
            cfg_first                <= `REG_RESET_VALUE;
            cfg_second               <= `REG_RESET_VALUE;
        end else if (do_write) begin
            case (i_command)
                `OFS_VENDOR_ID_LOW:   o_vendor_code_low_byte <= kept_data;
                `OFS_VENDOR_ID_HIGH:  o_vendor_code_high_byte <= kept_data;
                `OFS_PRODUCT_ID_LOW:  o_product_code_low_byte <= kept_data;
                `OFS_PRODUCT_ID_HIGH: o_product_code_high_byte <= kept_data;
                `OFS_DEVICE_ID_LOW:   o_release_code_low_byte <= kept_data;
                `OFS_DEVICE_ID_HIGH:  o_release_code_high_byte <= kept_data;
                `OFS_HUB_CONFIG_FIRST:  cfg_first <= kept_data;
                `OFS_HUB_CONFIG_SECOND: cfg_second <= kept_data;
                default: ;
            endcase
        end
    end

    // Read answer two cycles after the strobe; offsets outside the
    // bank read zero, since the engine owns those registers
    always @(posedge i_clk) begin
        if (i_reset) begin
            rd_pending <= 1'b0;
            rd_in_bank <= 1'b0;
            o_rvalid   <= 1'b0;
            o_rdata    <= 8'h00;
        end else begin
            rd_pending <= i_read_byte && !i_other_protocol;
            rd_in_bank <= in_bank(i_command);
            o_rvalid   <= 1'b0;
            if (rd_pending) begin
                o_rvalid <= 1'b1;
                o_rdata  <= rd_in_bank ? store_rdata : 8'h00;
            end
        end
    end

    // Refusal pulse for writes blocked by the lock
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_write_refused    <= 1'b0;
            o_config_lock_flag <= 1'b0;
        end else begin
            o_write_refused    <= i_write_byte && !i_other_protocol &&
                                  in_bank(i_command) && lock;
            o_config_lock_flag <= lock;
        end
    end

    // Decoded configuration fields for the hub core
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_self_powered               <= 1'b0;
            o_led_indicator_support      <= 1'b0;
            o_full_speed_only            <= 1'b0;
            o_per_port_translator_enable <= 1'b0;
            o_frame_end_packet_suppress  <= 1'b0;
            o_overcurrent_sense_mode     <= 2'h0;
            o_overcurrent_sense_off      <= 1'b0;
            o_port_power_switch_mode     <= 1'b0;
            o_dynamic_power_enable       <= 1'b0;
        end else begin
            // Dynamic mode ignores the select bit and follows the pin
            if (cfg_second[`HUB_CONFIG_SECOND_DYNAMIC_POWER]) begin
                o_self_powered <= sense_sync;
            end else begin
                o_self_powered <= cfg_first[`CFG1_POWER_SOURCE];
            end
            o_led_indicator_support <= cfg_first[`CFG1_LED_SUPPORT];
            o_full_speed_only <= cfg_first[`CFG1_FULL_SPEED_ONLY];
            o_per_port_translator_enable <=
                cfg_first[`CFG1_PER_PORT_TT];
            o_frame_end_packet_suppress <=
                cfg_first[`CFG1_EOP_SUPPRESS];
            o_overcurrent_sense_mode <=
                cfg_first[`CFG1_OC_MODE_HI:`CFG1_OC_MODE_LO];
            // Upper bit alone disables sensing; host keeps it to bus power
            o_overcurrent_sense_off <= cfg_first[`CFG1_OC_MODE_HI];
            o_port_power_switch_mode <= cfg_first[`CFG1_PORT_POWER];
            o_dynamic_power_enable <= cfg_second[`HUB_CONFIG_SECOND_DYNAMIC_POWER];
        end
    end

endmodule

// ---- tb/hub_identity_config_registers_properties.sv ----
// Checker for the hub identity and configuration register bank.
// Bound to the bank's top module; sees its ports only.
`timescale 1ns/100ps
module hub_regs_properties (
    input wire       i_clk,              // Clock
    input wire       i_reset,            // Sync reset
    input wire       i_write_byte,       // Write strobe
    input wire       i_read_byte,        // Read strobe
    input wire       i_other_protocol,   // Bad protocol
    input wire [7:0] i_command,          // Offset
    input wire [7:0] i_wdata,            // Write byte
    input wire       o_rvalid,           // Read valid
    input wire       o_write_refused,    // Refused pulse
    input wire       o_config_lock_flag, // Lock state
    input wire [7:0] o_vendor_code_low_byte, // Vendor low
    input wire       o_full_speed_only,  // Speed bit
    input wire [1:0] o_overcurrent_sense_mode, // Sense mode
    input wire       o_overcurrent_sense_off   // Sensing off
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Accepted write; lock seen from its registered flag
    wire wr_ok = i_write_byte && !i_other_protocol && !o_config_lock_flag;

    property p_read_answer; i_read_byte && !i_other_protocol |-> ##2 o_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered");
    property p_other_ignored; i_read_byte && i_other_protocol |-> ##2 !o_rvalid;
    endproperty
    a_other_ignored: assert property (p_other_ignored)
        else $error("other protocol answered");
    property p_vendor_low; wr_ok && i_command == 8'h01
        |=> o_vendor_code_low_byte == $past(i_wdata); endproperty
    a_vendor_low: assert property (p_vendor_low)
        else $error("vendor low not stored");
    property p_cfg_speed; wr_ok && i_command == 8'h07
        |-> ##2 o_full_speed_only == $past(i_wdata[5], 2); endproperty
    a_cfg_speed: assert property (p_cfg_speed)
        else $error("speed bit wrong");
    property p_oc_off; o_overcurrent_sense_off == o_overcurrent_sense_mode[1];
    endproperty
    a_oc_off: assert property (p_oc_off)
        else $error("sensing off mismatch");
    property p_refuse; i_write_byte && !i_other_protocol && o_config_lock_flag
        && i_command >= 8'h01 && i_command <= 8'h08 |=> o_write_refused;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("locked write not refused");
    property p_lock_hold; o_config_lock_flag |=> o_config_lock_flag; endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lock dropped");
    // Reset itself is the cause here, so no disable
    property p_reset_clear; disable iff (1'b0) i_reset |=> !o_full_speed_only
        && o_vendor_code_low_byte == 8'h00 && !o_config_lock_flag; endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset value wrong");
endmodule

// ---- tb/smbus_host_model.sv ----
// Host model presenting decoded Write Byte / Read Byte transfers.
// Assumes the bank samples strobes on the rising clock edge.
`timescale 1ns/100ps
module smbus_host_model (
    input  wire       i_clk,            // Clock
    input  wire       i_rvalid,         // Read valid
    input  wire [7:0] i_rdata,          // Read byte
    output reg        o_write_byte,     // Write strobe
    output reg        o_read_byte,      // Read strobe
    output reg        o_other_protocol, // Bad protocol
    output reg  [7:0] o_command,        // Offset
    output reg  [7:0] o_wdata,          // Write byte
    output reg        o_lock_set        // Lock request
);
    // Idle from time zero
    initial begin
        {o_write_byte, o_read_byte, o_other_protocol, o_lock_set} = 4'h0;
        o_command = 8'h00;
        o_wdata = 8'h00;
    end
    // Never asks for no sensing while self powered; released lines invert
    task wr(input [7:0] cmd, input [7:0] data, input other);
        begin
            @(negedge i_clk);
            o_command = cmd;
            o_wdata = (cmd == 8'h07 && data[7]) ? data & 8'hFB : data;
            o_other_protocol = other;
            o_write_byte = 1'b1;
            @(negedge i_clk);
            {o_write_byte, o_other_protocol} = 2'h0;
            o_command = ~cmd;
            o_wdata = ~data;
        end
    endtask
    // Bounded wait for the answer
    task rd(input [7:0] cmd, input other, output [7:0] data, output ok);
        integer n;
        begin
            ok = 1'b0;
            data = 8'h00;
            @(negedge i_clk);
            o_command = cmd;
            o_other_protocol = other;
            o_read_byte = 1'b1;
            @(negedge i_clk);
            {o_read_byte, o_other_protocol} = 2'h0;
            o_command = ~cmd;
            for (n = 0; n < 3; n = n + 1) begin
                @(posedge i_clk);
                #1;
                if (i_rvalid && !ok) begin
                    data = i_rdata;
                    ok = 1'b1;
                end
            end
        end
    endtask
    task lock;
        begin
            @(negedge i_clk);
            o_lock_set = 1'b1;
            @(negedge i_clk);
            o_lock_set = 1'b0;
        end
    endtask
endmodule

// ---- tb/hub_identity_config_registers_tb.sv ----
// Testbench for the hub identity and configuration register bank.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/100ps
module hub_identity_config_registers_tb;
    reg        i_clk, i_reset, i_local_power_sense_pin;
    wire       i_write_byte, i_read_byte, i_other_protocol, i_lock_set;
    wire [7:0] i_command, i_wdata, o_rdata;
    wire       o_rvalid, o_write_refused, o_config_lock_flag;
    wire [7:0] o_vendor_code_low_byte, o_vendor_code_high_byte;
    wire [7:0] o_product_code_low_byte, o_product_code_high_byte;
    wire [7:0] o_release_code_low_byte, o_release_code_high_byte;
    wire       o_self_powered, o_led_indicator_support, o_full_speed_only;
    wire       o_per_port_translator_enable, o_frame_end_packet_suppress;
    wire [1:0] o_overcurrent_sense_mode;
    wire       o_overcurrent_sense_off, o_port_power_switch_mode;
    wire       o_dynamic_power_enable;
    integer    fails, checks, k;
    reg  [7:0] d;
    reg        ok;
    // First configuration byte as seen at the decoded outputs
    wire [7:0] cfg1_seen = {o_self_powered, o_led_indicator_support,
        o_full_speed_only, o_per_port_translator_enable,
        o_frame_end_packet_suppress, o_overcurrent_sense_mode,
        o_port_power_switch_mode};

    hub_identity_config_registers u_dut (.*);
    smbus_host_model u_host (.i_clk(i_clk), .i_rvalid(o_rvalid),
        .i_rdata(o_rdata), .o_write_byte(i_write_byte),
        .o_read_byte(i_read_byte), .o_other_protocol(i_other_protocol),
        .o_command(i_command), .o_wdata(i_wdata), .o_lock_set(i_lock_set));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    task check(input [7:0] seen, input [7:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d fails %0d", checks, fails);
            if (fails == 0 && checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // A lost answer ends the run
    task rd(input [7:0] cmd, input [7:0] exp);
        begin
            u_host.rd(cmd, 1'b0, d, ok);
            if (!ok) begin
                fails = fails + 1;
                conclude;
            end
            check(d, exp);
        end
    endtask
    task do_reset;
        begin
            @(negedge i_clk);
            i_reset = 1'b1;
            repeat (4) @(negedge i_clk);
            i_reset = 1'b0;
        end
    endtask
    task t_identity;
        begin
            for (k = 1; k <= 6; k = k + 1)
                u_host.wr(k[7:0], 8'hA0 + k[7:0], 1'b0);
            @(negedge i_clk);
            check(o_vendor_code_low_byte, 8'hA1);
            check(o_vendor_code_high_byte, 8'hA2);
            check(o_product_code_low_byte, 8'hA3);
            check(o_product_code_high_byte, 8'hA4);
            check(o_release_code_low_byte, 8'hA5);
            check(o_release_code_high_byte, 8'hA6);
            for (k = 1; k <= 6; k = k + 1)
                rd(k[7:0], 8'hA0 + k[7:0]);
        end
    endtask
    // Decoded outputs land two edges after the write
    task cfg(input [7:0] v);
        begin
            u_host.wr(8'h07, v, 1'b0);
            repeat (2) @(negedge i_clk);
            check(cfg1_seen, v);
            check({7'h00, o_overcurrent_sense_off}, {7'h00, v[2]});
            rd(8'h07, v);
        end
    endtask
    // Sense pin is synchronised, so wait a bounded while
    task sp(input v);
        integer n;
        begin
            @(negedge i_clk);
            i_local_power_sense_pin = v;
            for (n = 0; n < 8 && o_self_powered !== v; n = n + 1)
                @(negedge i_clk);
            check({7'h00, o_self_powered}, {7'h00, v});
            if (n == 8)
                conclude;
        end
    endtask
    task t_power;
        begin
            u_host.wr(8'h08, 8'hFF, 1'b0);
            rd(8'h08, 8'hBF);
            check({7'h00, o_dynamic_power_enable}, 8'h01);
            sp(1'b0);
            sp(1'b1);
            sp(1'b0);
        end
    endtask
    task t_other_lock;
        begin
            u_host.wr(8'h01, 8'h3C, 1'b1);
            u_host.rd(8'h01, 1'b1, d, ok);
            check({7'h00, ok}, 8'h00);
            rd(8'h01, 8'hA1);
            u_host.lock;
            u_host.wr(8'h02, 8'h55, 1'b0);
            // Refusal pulse stands only for the cycle after the strobe
            check({7'h00, o_write_refused}, 8'h01);
            check({7'h00, o_config_lock_flag}, 8'h01);
            rd(8'h02, 8'hA2);
            do_reset;
            check({7'h00, o_config_lock_flag}, 8'h00);
            rd(8'h01, 8'h00);
            u_host.wr(8'h02, 8'h55, 1'b0);
            rd(8'h02, 8'h55);
        end
    endtask
    initial begin
        i_reset = 1'b1;
        fails = 0;
        checks = 0;
        i_local_power_sense_pin = 1'b0;
        do_reset;
        for (k = 1; k <= 8; k = k + 1)
            rd(k[7:0], 8'h00);
        rd(8'h20, 8'h00);
        t_identity;
        cfg(8'h7D);
        cfg(8'h00);
        cfg(8'hA2);
        t_power;
        t_other_lock;
        conclude;
    end
endmodule

bind hub_identity_config_registers hub_regs_properties u_chk (.*);
